// ==== hw/irq_map_pkg.sv ====
// Package: vector slots, addresses and source layout for the interrupt map
package irq_map_pkg;
    // ------------------------------------------------------------
    // Vector numbers and addresses
    // ------------------------------------------------------------
    localparam logic [3:0] VEC_RESERVED13 = 4'hd;
    localparam logic [3:0] VEC_TICK = 4'hc;
    localparam logic [3:0] VEC_LF = 4'hb;
    localparam logic [3:0] VEC_RESERVED10 = 4'ha;
    localparam logic [3:0] VEC_RADIO = 4'h9;
    localparam logic [3:0] VEC_RESERVED8 = 4'h8;
    localparam logic [3:0] VEC_TIMER_WRAP = 4'h7;
    localparam logic [3:0] VEC_TIMER_CHAN1 = 4'h6;
    localparam logic [3:0] VEC_NONE = 4'h0;
    // Vector n sits at TOP - 2n; high byte low address
    localparam logic [15:0] VEC_TABLE_TOP = 16'hdffe;
    // ------------------------------------------------------------
    // Source index positions in the flag/clear vectors
    // ------------------------------------------------------------
    localparam int SRC_COUNT = 10;
    localparam int SRC_TICK = 0;
    localparam int SRC_LF_WAKE_IDENT = 1;
    localparam int SRC_LF_CARRIER = 2;
    localparam int SRC_LF_DECODE_ERR = 3;
    localparam int SRC_LF_BYTE_READY = 4;
    localparam int SRC_RADIO_DONE = 5;
    localparam int SRC_RADIO_ERR = 6;
    localparam int SRC_TIMER_WRAP = 7;
    localparam int SRC_TIMER_CHAN1 = 8;
    localparam int SRC_RESERVED = 9;
    // ------------------------------------------------------------
    // Receiver modes and reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LF_MODE_DATA = 2'h0,
        LF_MODE_CARRIER = 2'h1,
        LF_MODE_MANCHESTER = 2'h2,
        LF_MODE_OFF = 2'h3
    } lf_mode_t;
    localparam logic [15:0] VEC_ADDR_RESET = 16'h0000;
endpackage

// ==== hw/vector_select.sv ====
// Fixed-priority pick of the lowest-numbered pending vector slot
`timescale 1ns/1ps
module vector_select (
    // Pending lines per slot, index = vector number
    input wire logic [15:0] pending,
    // Chosen slot and a valid flag
    output logic [3:0] vec_num,
    output logic valid
);
    import irq_map_pkg::*;

    // Lower number wins, so scan downward and keep the last hit
    always_comb begin
        vec_num = VEC_NONE;
        valid = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (pending[i]) begin
                vec_num = 4'(i);
                valid = 1'b1;
            end
        end
    end
endmodule

// ==== hw/interrupt_vector_map.sv ====
// Interrupt request mapping for vector slots 13 down to 6
`timescale 1ns/1ps
module interrupt_vector_map (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Source events, one-cycle pulses from peripheral logic, plus the sleep and LF mode levels that gate them
    input wire logic tick_timeout,
    input wire logic light_sleep_mode,
    input wire logic in_stop,
    input wire irq_map_pkg::lf_mode_t lf_mode,
    input wire logic lf_wake_ident_seen,
    input wire logic lf_carrier_seen,
    input wire logic lf_decode_error_seen,
    input wire logic lf_byte_seen,
    input wire logic radio_buffer_sent,
    input wire logic radio_error_seen,
    input wire logic timer_overflow,
    input wire logic timer_chan1_event,
    // Flag clear strobes from software, bit per source
    input wire logic [9:0] flag_clear,
    // Local enables
    input wire logic periodic_tick_irq_en,
    input wire logic lf_wake_ident_irq_en,
    input wire logic lf_carrier_irq_en,
    input wire logic lf_decode_error_irq_en,
    input wire logic lf_byte_ready_irq_en,
    input wire logic radio_irq_en,
    input wire logic timer_wrap_irq_en,
    input wire logic timer_chan1_irq_en,
    // CPU side
    input wire logic cpu_irq_mask,
    input wire logic vec_fetch_low,
    // Flags and requests
    output logic [9:0] flags,
    output logic cpu_irq_req,
    output logic [3:0] cpu_vec_num,
    output logic [15:0] cpu_vec_addr,
    output logic [15:0] vec_slot_req,
    output logic wake_req
);
    import irq_map_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte address of a vector slot; the high byte sits lower
    function automatic logic [15:0] vec_addr_of(input logic [3:0] n,
                                                input logic low_byte);
        vec_addr_of = VEC_TABLE_TOP - 16'({n, 1'b0}) + 16'(low_byte);
    endfunction

    // ------------------------------------------------------------
    // Source flags
    // ------------------------------------------------------------
    logic [9:0] flags_q, flags_d;
    logic [9:0] set_ev;
    logic tick_ok;

    always_comb begin
        tick_ok = !in_stop || light_sleep_mode;
        set_ev = '0;
        set_ev[SRC_TICK] = tick_timeout && tick_ok;
        set_ev[SRC_LF_WAKE_IDENT] =
            lf_wake_ident_seen && lf_mode == LF_MODE_DATA;
        set_ev[SRC_LF_CARRIER] =
            lf_carrier_seen && lf_mode == LF_MODE_CARRIER;
        set_ev[SRC_LF_DECODE_ERR] =
            lf_decode_error_seen && lf_mode == LF_MODE_MANCHESTER;
        set_ev[SRC_LF_BYTE_READY] =
            lf_byte_seen && lf_mode == LF_MODE_MANCHESTER;
        set_ev[SRC_RADIO_DONE] = radio_buffer_sent;
        set_ev[SRC_RADIO_ERR] = radio_error_seen;
        set_ev[SRC_TIMER_WRAP] = timer_overflow;
        set_ev[SRC_TIMER_CHAN1] = timer_chan1_event;
        // A set in the clearing cycle wins so no event is lost
        flags_d = (flags_q & ~flag_clear) | set_ev;
        flags_d[SRC_RESERVED] = 1'b0;
    end

    // ------------------------------------------------------------
    // Slot requests
    // ------------------------------------------------------------
    logic [15:0] slot_d;

    always_comb begin
        slot_d = '0;
        slot_d[VEC_TICK] =
            flags_q[SRC_TICK] && periodic_tick_irq_en;
        slot_d[VEC_LF] =
            (flags_q[SRC_LF_WAKE_IDENT] && lf_wake_ident_irq_en) ||
            (flags_q[SRC_LF_CARRIER] && lf_carrier_irq_en) ||
            (flags_q[SRC_LF_DECODE_ERR] && lf_decode_error_irq_en) ||
            (flags_q[SRC_LF_BYTE_READY] && lf_byte_ready_irq_en);
        slot_d[VEC_RADIO] = radio_irq_en &&
            (flags_q[SRC_RADIO_DONE] || flags_q[SRC_RADIO_ERR]);
        slot_d[VEC_TIMER_WRAP] =
            flags_q[SRC_TIMER_WRAP] && timer_wrap_irq_en;
        slot_d[VEC_TIMER_CHAN1] =
            flags_q[SRC_TIMER_CHAN1] && timer_chan1_irq_en;
        // Reserved slots 13, 10, 8 stay at zero
    end

    logic [3:0] pick_num;
    logic pick_valid;

    vector_select u_select (
        .pending(slot_d),
        .vec_num(pick_num),
        .valid(pick_valid)
    );

    // ------------------------------------------------------------
    // CPU-facing outputs
    // ------------------------------------------------------------
    logic req_d;
    logic [3:0] num_d;
    logic [15:0] addr_d;
    logic wake_d;

    always_comb begin
        // Mask only stops the CPU taking it; wake still sees the slot
        req_d = pick_valid && !cpu_irq_mask;
        num_d = pick_valid ? pick_num : VEC_NONE;
        addr_d = pick_valid ? vec_addr_of(pick_num, vec_fetch_low)
                            : VEC_ADDR_RESET;
        wake_d = pick_valid;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            flags_q <= '0;
            vec_slot_req <= '0;
            cpu_irq_req <= 1'b0;
            cpu_vec_num <= VEC_NONE;
            cpu_vec_addr <= VEC_ADDR_RESET;
            wake_req <= 1'b0;
        end else begin
            flags_q <= flags_d;
            vec_slot_req <= slot_d;
            cpu_irq_req <= req_d;
            cpu_vec_num <= num_d;
            cpu_vec_addr <= addr_d;
            wake_req <= wake_d;
        end
    end

    assign flags = flags_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_tick_set;
        tick_timeout && tick_ok && !srst;
    endsequence

    property p_tick_flag;
        @(posedge clock) disable iff (srst)
        s_tick_set |=> flags[SRC_TICK];
    endproperty
    a_tick_flag: assert property (p_tick_flag)
        else $error("tick flag not set");

    property p_lf_mode;
        @(posedge clock) disable iff (srst)
        (lf_carrier_seen && lf_mode != LF_MODE_CARRIER &&
         !flags[SRC_LF_CARRIER]) |=> !flags[SRC_LF_CARRIER];
    endproperty
    a_lf_mode: assert property (p_lf_mode)
        else $error("carrier flag set outside carrier mode");

    property p_reserved;
        @(posedge clock) disable iff (srst)
        !vec_slot_req[VEC_RESERVED13] && !vec_slot_req[VEC_RESERVED10] &&
        !vec_slot_req[VEC_RESERVED8];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved slot requested");

    sequence s_radio_err_held;
        (radio_error_seen && radio_irq_en) ##1 radio_irq_en;
    endsequence

    property p_radio_err;
        @(posedge clock) disable iff (srst)
        s_radio_err_held |=> vec_slot_req[VEC_RADIO];
    endproperty
    a_radio_err: assert property (p_radio_err)
        else $error("radio error did not request vector 9");

    property p_mask;
        @(posedge clock) disable iff (srst)
        $past(cpu_irq_mask) |-> !cpu_irq_req;
    endproperty
    a_mask: assert property (p_mask)
        else $error("request passed while masked");

    property p_priority;
        @(posedge clock) disable iff (srst)
        (cpu_vec_num == VEC_RADIO) |-> !vec_slot_req[VEC_TIMER_WRAP] &&
        !vec_slot_req[VEC_TIMER_CHAN1];
    endproperty
    a_priority: assert property (p_priority)
        else $error("lower priority vector chosen");

    property p_addr;
        @(posedge clock) disable iff (srst)
        (cpu_vec_num == VEC_TIMER_WRAP && !$past(vec_fetch_low))
        |-> cpu_vec_addr == 16'hdff0;
    endproperty
    a_addr: assert property (p_addr)
        else $error("vector address wrong");

    sequence s_chan1_held;
        (timer_chan1_event && timer_chan1_irq_en) ##1 timer_chan1_irq_en;
    endsequence

    property p_wake;
        @(posedge clock) disable iff (srst)
        s_chan1_held |=> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on pending vector");

    // No other source may set in the two cycles, or its own request shows
    sequence s_wrap_cleared;
        (flags == 10'(1 << SRC_TIMER_WRAP) && flag_clear[SRC_TIMER_WRAP]
         && set_ev == '0) ##1 (set_ev == '0);
    endsequence

    property p_clear_drop;
        @(posedge clock) disable iff (srst)
        s_wrap_cleared |=> !cpu_irq_req;
    endproperty
    a_clear_drop: assert property (p_clear_drop)
        else $error("request stayed after clear");
endmodule

// ==== testbench/cpu_model.sv ====
// CPU side model: fetches both vector bytes for each request
`timescale 1ns/1ps
module cpu_model (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Request and vector address from the map
    input wire logic cpu_irq_req,
    input wire logic [15:0] cpu_vec_addr,
    // Byte select and fetched results
    output logic vec_fetch_low,
    output logic [15:0] hi_addr,
    output logic [15:0] lo_addr,
    output logic fetched
);
    initial begin
        vec_fetch_low = 1'b0;
        hi_addr = 16'h0000;
        lo_addr = 16'h0000;
        fetched = 1'b0;
        forever begin
            @(posedge clock);
            fetched <= 1'b0;
            if (!srst && cpu_irq_req) begin
                // Byte select acts one edge late, so wait two
                repeat (2) @(posedge clock);
                hi_addr <= cpu_vec_addr;
                vec_fetch_low <= 1'b1;
                repeat (2) @(posedge clock);
                lo_addr <= cpu_vec_addr;
                vec_fetch_low <= 1'b0;
                fetched <= 1'b1;
                // Leave the handler time to clear its flag
                repeat (4) @(posedge clock);
            end
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking testbench for the interrupt vector map
`timescale 1ns/1ps
module tb_top;
    import irq_map_pkg::*;
    logic clock, srst, light_sleep_mode, in_stop, cpu_irq_mask;
    lf_mode_t lf_mode;
    logic [8:0] ev;
    logic [7:0] en;
    logic [9:0] flag_clear, flags;
    logic cpu_irq_req, vec_fetch_low, wake_req, fetched;
    logic [3:0] cpu_vec_num;
    logic [15:0] cpu_vec_addr, vec_slot_req, hi_addr, lo_addr;
    int miscompares = 0;
    int checks_done = 0;
    int vn[9] = '{12, 11, 11, 11, 11, 9, 9, 7, 6};
    int en_ix[9] = '{0, 1, 2, 3, 4, 5, 5, 6, 7};
    int md[9] = '{0, 0, 1, 2, 2, 0, 0, 0, 0};
    interrupt_vector_map uut (.clock(clock), .srst(srst),
        .tick_timeout(ev[0]), .light_sleep_mode(light_sleep_mode),
        .in_stop(in_stop), .lf_mode(lf_mode),
        .lf_wake_ident_seen(ev[1]), .lf_carrier_seen(ev[2]),
        .lf_decode_error_seen(ev[3]), .lf_byte_seen(ev[4]),
        .radio_buffer_sent(ev[5]), .radio_error_seen(ev[6]),
        .timer_overflow(ev[7]), .timer_chan1_event(ev[8]),
        .flag_clear(flag_clear), .periodic_tick_irq_en(en[0]),
        .lf_wake_ident_irq_en(en[1]), .lf_carrier_irq_en(en[2]),
        .lf_decode_error_irq_en(en[3]), .lf_byte_ready_irq_en(en[4]),
        .radio_irq_en(en[5]), .timer_wrap_irq_en(en[6]),
        .timer_chan1_irq_en(en[7]), .cpu_irq_mask(cpu_irq_mask),
        .vec_fetch_low(vec_fetch_low), .flags(flags),
        .cpu_irq_req(cpu_irq_req), .cpu_vec_num(cpu_vec_num),
        .cpu_vec_addr(cpu_vec_addr), .vec_slot_req(vec_slot_req),
        .wake_req(wake_req));
    cpu_model cpu (.clock(clock), .srst(srst), .cpu_irq_req(cpu_irq_req),
        .cpu_vec_addr(cpu_vec_addr), .vec_fetch_low(vec_fetch_low),
        .hi_addr(hi_addr), .lo_addr(lo_addr), .fetched(fetched));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic fire(input int s);
        ev[s] = 1'b1;
        step(1);
        ev[s] = 1'b0;
    endtask
    task automatic clear(input int s);
        flag_clear[s] = 1'b1;
        step(1);
        flag_clear[s] = 1'b0;
    endtask
    task automatic wait_fetch();
        int n;
        n = 0;
        while (fetched !== 1'b1 && n < 50) begin
            step(1);
            n++;
        end
        chk("fetch done", 16'h0001, {15'h0000, fetched});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic each_source();
        for (int s = 0; s < 9; s++) begin
            en = 8'h00;
            en[en_ix[s]] = 1'b1;
            lf_mode = lf_mode_t'(md[s]);
            step(1);
            fire(s);
            step(1);
            chk("flag", 16'(1 << s), {6'h00, flags});
            step(1);
            chk("vector", 16'(vn[s]), {12'h000, cpu_vec_num});
            chk("slots", 16'(1 << vn[s]), vec_slot_req);
            wait_fetch();
            chk("high addr", 16'hdffe - 16'(2 * vn[s]), hi_addr);
            chk("low addr", 16'hdfff - 16'(2 * vn[s]), lo_addr);
            clear(s);
            step(2);
            chk("req cleared", 16'h0000, {15'h0000, cpu_irq_req});
        end
    endtask
    task automatic gating();
        en = 8'h00;
        lf_mode = LF_MODE_CARRIER;
        fire(7);
        fire(1);
        // Carrier and decoder events must be ignored in data mode
        lf_mode = LF_MODE_DATA;
        fire(2);
        fire(4);
        step(2);
        chk("flags no enable", 16'h0080, {6'h00, flags});
        chk("slots no enable", 16'h0000, vec_slot_req);
        en = 8'hff;
        cpu_irq_mask = 1'b1;
        step(3);
        chk("masked req", 16'h0000, {15'h0000, cpu_irq_req});
        chk("wake masked", 16'h0001, {15'h0000, wake_req});
        clear(7);
        in_stop = 1'b1;
        fire(0);
        step(1);
        chk("tick deep stop", 16'h0000, {6'h00, flags});
        light_sleep_mode = 1'b1;
        fire(0);
        step(1);
        chk("tick light sleep", 16'h0001, {6'h00, flags});
        clear(0);
        cpu_irq_mask = 1'b0;
        in_stop = 1'b0;
        light_sleep_mode = 1'b0;
        step(3);
    endtask
    task automatic pick_order();
        fire(0);
        fire(5);
        fire(8);
        step(2);
        chk("slots pending", 16'h1240, vec_slot_req);
        chk("winner", 16'h0006, {12'h000, cpu_vec_num});
        clear(8);
        step(2);
        chk("next winner", 16'h0009, {12'h000, cpu_vec_num});
        fire(6);
        clear(5);
        step(2);
        chk("radio error", 16'h0200, vec_slot_req & 16'h0200);
        clear(6);
        clear(0);
        step(3);
        chk("all idle", 16'h0000, vec_slot_req);
    endtask
    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        ev = 9'h000;
        en = 8'h00;
        flag_clear = 10'h000;
        lf_mode = LF_MODE_OFF;
        light_sleep_mode = 1'b0;
        in_stop = 1'b0;
        cpu_irq_mask = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        srst = 1'b0;
        step(1);
        each_source();
        gating();
        pick_order();
        print_verdict();
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
endmodule
